/* File: pkg/sdcam_pkg.sv */
// Constants and carrier types for the SDRAM connection and address multiplexer
package sdcam_pkg;

  // Bus size codes of an SDRAM area
  localparam logic [1:0] BSZ_16 = 2'h2;
  localparam logic [1:0] BSZ_32 = 2'h3;
  // Row and column width codes; code 3 is unsupported in both fields
  localparam logic [1:0] WIDTH_CODE_BAD = 2'h3;
  localparam logic [4:0] ROW_BASE_BITS  = 5'h0b;
  localparam logic [4:0] COL_BASE_BITS  = 5'h08;
  // Pin map
  localparam int         ADDR_W         = 28;
  localparam int         PIN_W          = 26;
  localparam int         MUX_PINS       = 18;
  localparam logic [4:0] PRE_SDRAM_BIT  = 5'h0a;
  localparam logic [4:0] PIN_OFS_16     = 5'h01;
  localparam logic [4:0] PIN_OFS_32     = 5'h02;
  localparam int         LANE_N         = 4;
  localparam logic [3:0] MASK_ALL_OFF   = 4'hf;
  localparam logic [3:0] MASK_HALF16    = 4'hc;

  // Request codes from the bus master
  typedef enum logic [3:0] {
    nop_cmd, auto_refresh_cmd, self_refresh_cmd, precharge_all_cmd,
    precharge_bank_cmd, activate_cmd, read_cmd, read_autoprecharge_cmd,
    write_cmd, write_autoprecharge_cmd, mode_register_set_cmd
  } sdcam_cmd_t;

  // Strobe triples {row strobe, column strobe, read/write line}, all active low
  localparam logic [2:0] STB_NOP  = 3'h7;
  localparam logic [2:0] STB_REF  = 3'h1;
  localparam logic [2:0] STB_PRE  = 3'h2;
  localparam logic [2:0] STB_ACT  = 3'h3;
  localparam logic [2:0] STB_READ = 3'h5;
  localparam logic [2:0] STB_WR   = 3'h4;
  localparam logic [2:0] STB_MRS  = 3'h0;

  typedef struct packed {
    logic [1:0] bus_size_field;
    logic [1:0] row_width_field;
    logic [1:0] column_width_field;
  } sdcam_area_cfg_t;

  typedef struct packed {
    logic               valid;
    sdcam_cmd_t         cmd;
    logic               area3;    // 1 selects area 3, 0 selects area 2
    logic [ADDR_W-1:0]  addr;
    logic [LANE_N-1:0]  byte_en;  // Active high, lane 3 is the top byte
  } sdcam_req_t;

  typedef struct packed {
    logic              row_strobe_b;
    logic              col_strobe_b;
    logic              read_write_line;
    logic              cke;
    logic              area2_select_b;
    logic              area3_select_b;
    logic              byte_mask_lane3_b;
    logic              byte_mask_lane2_b;
    logic              byte_mask_lane1_b;
    logic              byte_mask_lane0_b;
    logic [PIN_W-1:0]  addr;
  } sdcam_pins_t;

  typedef struct packed {
    sdcam_pins_t pins;
    logic        refused;
  } sdcam_state_t;

  localparam sdcam_state_t SDCAM_STATE_RST = '{
    pins: '{row_strobe_b: 1'b1, col_strobe_b: 1'b1, read_write_line: 1'b1, cke: 1'b1,
            area2_select_b: 1'b1, area3_select_b: 1'b1, byte_mask_lane3_b: 1'b1,
            byte_mask_lane2_b: 1'b1, byte_mask_lane1_b: 1'b1, byte_mask_lane0_b: 1'b1,
            addr: '0},
    refused: 1'b0};

endpackage

/* File: rtl/sdcam_top.sv */
// SDRAM command encoder, byte-lane masks, area selects and row/column address multiplexer
//
// Contract
// - Parts with 11/12/13 row bits, 8/9/10 column bits, four banks, pin 10 precharge.
// - Strobes and masks shared by both areas; only area selects qualify them.
// - At most two SDRAM spaces, areas 2 and 3, each with its own select.
// - Each SDRAM area is either 32 or 16 bits wide.
// - Burst length 1 only: every read or write is one command.
// - Commands encoded on row strobe, column strobe, read/write line and address pins.
// - Four active-low lane masks; a byte moves only when its mask is low.
// - A single SDRAM area is area 3; area 2 then holds other memory.
// - Row and column multiplexed internally; unlisted settings are undefined.
// - Pins A25 to A18 always carry the plain address bits.
// - 16-bit bus: SDRAM address bit 0 sits on pin A1.
// - 32-bit bus: SDRAM address bit 0 sits on pin A2.
// - Row codes 00/01/10 give 11/12/13 bits; row pin A0 carries bit column-width.
// - Column codes 00/01/10 give 8/9/10 bits; column pins carry same-index bits.
// - 32-bit 11x8: banks on A14,A13 from A22,A21; precharge on A12.
// - 32-bit 12x8: banks on A15,A14 from A23,A22; precharge on A12.
// - 32-bit 13x9: banks on A16,A15 from A25,A24; precharge on A12.
// - 16-bit 11x8: banks on A13,A12 from A21,A20; precharge on A11.
// - Column-phase precharge pin carries the access-mode level, not an address bit.
`timescale 1ns/1ns
module sdcam_top
  import sdcam_pkg::*;
(
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst_b,
  // Area configuration
  input  wire logic            area2_sdram_en,
  input  wire sdcam_area_cfg_t area2_cfg,
  input  wire sdcam_area_cfg_t area3_cfg,
  // Request from the bus master
  input  wire sdcam_req_t      req,
  // SDRAM pins and status
  output sdcam_pins_t          sdram_pins,
  output logic                 req_refused
);

  // Pin offset of SDRAM address bit 0 for a bus size
  function automatic logic [4:0] pin_offset(input logic [1:0] bsz);
    return (bsz == BSZ_16) ? PIN_OFS_16 : PIN_OFS_32;
  endfunction

  // Only the listed width combinations are accepted
  function automatic logic cfg_ok(input sdcam_area_cfg_t c);
    return (c.bus_size_field == BSZ_16 || c.bus_size_field == BSZ_32)
        && c.row_width_field != WIDTH_CODE_BAD
        && c.column_width_field != WIDTH_CODE_BAD;
  endfunction

  sdcam_state_t    s_r;
  sdcam_state_t    s_nxt;
  sdcam_area_cfg_t cfg;
  logic [4:0]      col_bits;
  logic [4:0]      pre_pin;
  logic [4:0]      bank_lo;
  logic [PIN_W-1:0] row_addr;
  logic [PIN_W-1:0] col_addr;
  logic [2:0]      stb;
  logic [3:0]      mask_b;
  logic            pre_level;
  logic            sel_ok;

  // Address phases for the addressed area
  always_comb begin
    cfg      = req.area3 ? area3_cfg : area2_cfg;
    col_bits = COL_BASE_BITS + 5'(cfg.column_width_field);
    pre_pin  = pin_offset(cfg.bus_size_field) + PRE_SDRAM_BIT;
    // Bank pins sit just above the top row bit on the SDRAM side
    bank_lo  = pin_offset(cfg.bus_size_field) + ROW_BASE_BITS
               + 5'(cfg.row_width_field);
    row_addr = req.addr[PIN_W-1:0];
    col_addr = req.addr[PIN_W-1:0];
    for (int i = 0; i < MUX_PINS; i++) begin
      row_addr[i] = req.addr[5'(i) + col_bits];
    end
    // Bank pins hold the row-phase value in the column phase too
    for (int i = 0; i < MUX_PINS; i++) begin
      if (5'(i) == bank_lo || 5'(i) == bank_lo + 5'h01) begin
        col_addr[i] = row_addr[i];
      end
    end
  end

  // Command decode, byte lanes and selects
  always_comb begin
    s_nxt        = s_r;
    s_nxt.refused = 1'b0;
    stb          = STB_NOP;
    mask_b       = MASK_ALL_OFF;
    pre_level    = 1'b0;
    sel_ok       = req.valid && cfg_ok(cfg)
                   && (req.area3 || area2_sdram_en);
    s_nxt.pins.area2_select_b = 1'b1;
    s_nxt.pins.area3_select_b = 1'b1;
    if (req.valid && !sel_ok) begin
      s_nxt.refused = 1'b1;
    end
    if (sel_ok) begin
      // Self refresh drops the clock enable; any later accepted request other than self refresh restores it
      s_nxt.pins.cke = (req.cmd != self_refresh_cmd);
      s_nxt.pins.area3_select_b = !req.area3;
      s_nxt.pins.area2_select_b = req.area3;
      unique case (req.cmd)
        nop_cmd: begin
          stb = STB_NOP;
        end
        auto_refresh_cmd, self_refresh_cmd: begin
          stb = STB_REF;
        end
        precharge_all_cmd, precharge_bank_cmd: begin
          stb       = STB_PRE;
          pre_level = (req.cmd == precharge_all_cmd);
          s_nxt.pins.addr = col_addr;
          s_nxt.pins.addr[pre_pin] = pre_level;
        end
        activate_cmd: begin
          stb = STB_ACT;
          s_nxt.pins.addr = row_addr;
        end
        read_cmd, read_autoprecharge_cmd, write_cmd, write_autoprecharge_cmd: begin
          // One command per beat: burst length 1
          stb = (req.cmd == read_cmd || req.cmd == read_autoprecharge_cmd)
                ? STB_READ : STB_WR;
          pre_level = (req.cmd == read_autoprecharge_cmd
                       || req.cmd == write_autoprecharge_cmd);
          s_nxt.pins.addr = col_addr;
          s_nxt.pins.addr[pre_pin] = pre_level;
          mask_b = ~req.byte_en;
          // Upper lanes carry nothing on a 16-bit part
          if (cfg.bus_size_field == BSZ_16) begin
            mask_b = mask_b | MASK_HALF16;
          end
        end
        mode_register_set_cmd: begin
          stb = STB_MRS;
          s_nxt.pins.addr = req.addr[PIN_W-1:0];
        end
        default: begin
          stb = STB_NOP;
        end
      endcase
    end
    // Shared strobes; the selects alone say which area listens
    s_nxt.pins.row_strobe_b    = stb[2];
    s_nxt.pins.col_strobe_b    = stb[1];
    s_nxt.pins.read_write_line = stb[0];
    s_nxt.pins.byte_mask_lane3_b = mask_b[3];
    s_nxt.pins.byte_mask_lane2_b = mask_b[2];
    s_nxt.pins.byte_mask_lane1_b = mask_b[1];
    s_nxt.pins.byte_mask_lane0_b = mask_b[0];
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= SDCAM_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sdram_pins  = s_r.pins;
  assign req_refused = s_r.refused;

endmodule

/* File: sim/sdcam_asserts.sv */
// Port-level checks for the SDRAM connection and address multiplexer
`timescale 1ns/1ns
module sdcam_asserts
  import sdcam_pkg::*;
(
  // Clock and reset
  input wire logic            clock,
  input wire logic            rst_b,
  // Configuration and request
  input wire logic            area2_sdram_en,
  input wire sdcam_area_cfg_t area2_cfg,
  input wire sdcam_area_cfg_t area3_cfg,
  input wire sdcam_req_t      req,
  // Pins and status
  input wire sdcam_pins_t     sdram_pins,
  input wire logic            req_refused
);
  logic [2:0] stb;
  logic [3:0] msk;
  logic       go3;
  // Flattened views; nop requests are left out because their select is a free choice
  assign stb = {sdram_pins.row_strobe_b, sdram_pins.col_strobe_b, sdram_pins.read_write_line};
  assign msk = {sdram_pins.byte_mask_lane3_b, sdram_pins.byte_mask_lane2_b,
                sdram_pins.byte_mask_lane1_b, sdram_pins.byte_mask_lane0_b};
  assign go3 = req.valid && req.area3 && req.cmd != nop_cmd;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  idle_quiet_a: assert property (!$past(req.valid) |-> stb == STB_NOP && msk == 4'hf)
    else $error("idle cycle not quiet");
  refused_quiet_a: assert property (req_refused |-> stb == STB_NOP
    && sdram_pins.area2_select_b && sdram_pins.area3_select_b) else $error("refused but active");
  area2_refuse_a: assert property (req.valid && !req.area3 && !area2_sdram_en |=> req_refused)
    else $error("area 2 request not refused");
  act_code_a: assert property (req.valid && req.cmd == activate_cmd ##1 !req_refused
    |-> stb == STB_ACT) else $error("activate strobes wrong");
  area3_select_a: assert property (go3 ##1 !req_refused
    |-> !sdram_pins.area3_select_b && sdram_pins.area2_select_b) else $error("select wrong");
  high_pins_a: assert property (req.valid && req.cmd inside {activate_cmd, read_cmd}
    ##1 !req_refused |-> sdram_pins.addr[25:18] == $past(req.addr[25:18]))
    else $error("high pins multiplexed");
  mask_wide_a: assert property (go3 && req.cmd == read_cmd && area3_cfg.bus_size_field == BSZ_32
    ##1 !req_refused |-> msk == ~$past(req.byte_en)) else $error("lane masks wrong");
  mask_half_a: assert property (go3 && area3_cfg.bus_size_field == BSZ_16
    && req.cmd inside {write_cmd, write_autoprecharge_cmd} ##1 !req_refused |-> msk[3:2] == 2'h3)
    else $error("upper lanes open on 16-bit bus");
  auto_pre_a: assert property (go3 && req.cmd == read_autoprecharge_cmd
    && area3_cfg.bus_size_field == BSZ_32 ##1 !req_refused |-> sdram_pins.addr[12])
    else $error("precharge pin low");
endmodule
bind sdcam_top sdcam_asserts u_chk (.clock(clock), .rst_b(rst_b), .area2_sdram_en(area2_sdram_en),
  .area2_cfg(area2_cfg), .area3_cfg(area3_cfg), .req(req), .sdram_pins(sdram_pins),
  .req_refused(req_refused));

/* File: sim/sdcam_sdram_model.sv */
// Far-side SDRAM model that counts read and write commands it accepts
`timescale 1ns/1ns
module sdcam_sdram_model
  import sdcam_pkg::*;
(
  // Clock and pins
  input  wire logic        clock,
  input  wire sdcam_pins_t pins,
  // Count of accepted data commands
  output int               n_data
);
  // Only a select qualifies a command; strobes alone must not be taken
  initial n_data = 0;
  always @(posedge clock) begin
    if (!(pins.area2_select_b && pins.area3_select_b) && pins.row_strobe_b
        && !pins.col_strobe_b) begin
      n_data <= n_data + 1;
    end
  end
endmodule

/* File: sim/test_sdram_connection_address_mux.sv */
// Self-checking bench for the SDRAM connection and address multiplexer
`timescale 1ns/1ns
module test_sdram_connection_address_mux;
  import sdcam_pkg::*;
  logic            clock = 1'b0;
  logic            rst_b = 1'b0;
  logic            en2   = 1'b1;
  sdcam_area_cfg_t c2    = 6'h30;
  sdcam_area_cfg_t c3    = 6'h30;
  sdcam_req_t      req   = '0;
  sdcam_pins_t     p;
  logic            refd;
  int              n_fail      = 0;
  int              comparisons = 0;
  int              seen;
  localparam logic [5:0] CFGS [12] = '{6'h30, 6'h34, 6'h35, 6'h36, 6'h39, 6'h3a,
                                       6'h20, 6'h24, 6'h25, 6'h26, 6'h29, 6'h2a};
  localparam logic [2:0] STB_X [11] = '{STB_NOP, STB_REF, STB_REF, STB_PRE, STB_PRE,
                                        STB_ACT, STB_READ, STB_READ, STB_WR, STB_WR, STB_MRS};
  always #10 clock = ~clock;
  sdcam_top dut (.clock(clock), .rst_b(rst_b), .area2_sdram_en(en2), .area2_cfg(c2),
                 .area3_cfg(c3), .req(req), .sdram_pins(p), .req_refused(refd));
  sdcam_sdram_model mem (.clock(clock), .pins(p), .n_data(seen));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One request for one edge; an idle edge follows so valid never toggles twice at once
  task automatic go(sdcam_cmd_t c, logic a3, logic [27:0] a, logic [3:0] be);
    @(negedge clock);
    req <= '{1'b1, c, a3, a, be};
    @(negedge clock);
    req.valid <= 1'b0;
  endtask
  // Row phase: low pins shifted by the column width, high pins plain
  function automatic logic [25:0] row_x(logic [27:0] a, sdcam_area_cfg_t g);
    return {a[25:18], 18'(a >> (8 + g.column_width_field))};
  endfunction
  // Column phase: bank pins keep row values, precharge pin takes the mode level
  function automatic logic [25:0] col_x(logic [27:0] a, sdcam_area_cfg_t g, logic lv);
    logic [25:0] r;
    int          o;
    int          b;
    r = a[25:0];
    o = (g.bus_size_field == BSZ_32) ? 2 : 1;
    b = o + 11 + g.row_width_field;
    r[b] = a[b + 8 + g.column_width_field];
    r[b + 1] = a[b + 9 + g.column_width_field];
    r[10 + o] = lv;
    return r;
  endfunction
  task automatic map_sweep();
    logic [27:0] a;
    foreach (CFGS[i]) begin
      a = 28'h5a3c96b ^ {7{4'(i)}};
      c3 = sdcam_area_cfg_t'(CFGS[i]);
      c2 = c3;
      go(activate_cmd, i[1], a, 4'hf);
      chk(p.addr, row_x(a, c3));
      chk({p.row_strobe_b, p.col_strobe_b, p.read_write_line, p.area2_select_b,
           p.area3_select_b}, {STB_ACT, i[1], !i[1]});
      go(i[0] ? write_autoprecharge_cmd : read_cmd, i[1], a, 4'h5);
      chk(p.addr, col_x(a, c3, i[0]));
      chk({p.byte_mask_lane3_b, p.byte_mask_lane2_b, p.byte_mask_lane1_b, p.byte_mask_lane0_b},
          (c3.bus_size_field == BSZ_32) ? 4'ha : 4'he);
    end
  endtask
  task automatic cmd_sweep();
    sdcam_cmd_t c;
    c3 = 6'h30;
    for (int k = 0; k < 11; k++) begin
      c = sdcam_cmd_t'(k);
      go(c, 1'b1, 28'h0a5f00d, 4'h3);
      chk({p.row_strobe_b, p.col_strobe_b, p.read_write_line}, STB_X[k]);
      chk(p.cke, c != self_refresh_cmd);
      if (c inside {precharge_all_cmd, precharge_bank_cmd}) chk(p.addr[12], k == 3);
    end
    chk(p.addr, 26'h0a5f00d);
  endtask
  task automatic refuse();
    en2 = 1'b0;
    go(read_cmd, 1'b0, 28'h1234567, 4'hf);
    chk({refd, p.row_strobe_b, p.area2_select_b}, 3'h7);
    en2 = 1'b1;
    c3 = 6'h3f;
    go(write_cmd, 1'b1, 28'h1234567, 4'hf);
    chk({refd, p.col_strobe_b, p.area3_select_b}, 3'h7);
    c3 = 6'h30;
  endtask
  // Watchdog sized well beyond the roughly 80 cycles the tests take
  initial begin
    #40000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    chk({p.row_strobe_b, p.col_strobe_b, p.area2_select_b, p.area3_select_b, p.cke}, 5'h1f);
    map_sweep();
    cmd_sweep();
    refuse();
    chk(seen, 16);
    tally_and_finish();
  end
endmodule
